// *** core/cit_pkg.sv ***
// package: register map, field layout and types of the composite interval timer
package cit_pkg;

  // ************************************************************
  // register offsets (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] OFS_U0_FUNC_LO = 8'h00;
  localparam logic [7:0] OFS_U0_FUNC_HI = 8'h04;
  localparam logic [7:0] OFS_U0_RUN_LO  = 8'h08;
  localparam logic [7:0] OFS_U0_RUN_HI  = 8'h0C;
  localparam logic [7:0] OFS_U0_OUTMODE = 8'h10;
  localparam logic [7:0] OFS_U0_DATA_LO = 8'h14;
  localparam logic [7:0] OFS_U0_DATA_HI = 8'h18;
  localparam logic [7:0] OFS_U1_FUNC_LO = 8'h20;
  localparam logic [7:0] OFS_U1_FUNC_HI = 8'h24;
  localparam logic [7:0] OFS_U1_RUN_LO  = 8'h28;
  localparam logic [7:0] OFS_U1_RUN_HI  = 8'h2C;
  localparam logic [7:0] OFS_U1_OUTMODE = 8'h30;
  localparam logic [7:0] OFS_U1_DATA_LO = 8'h34;
  localparam logic [7:0] OFS_U1_DATA_HI = 8'h38;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h44;
  localparam logic [7:0] OFS_UNIT_STRIDE = 8'h20;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int FUNC_GATE_BIT   = 7;
  localparam int RUN_REQ_BIT     = 7;
  localparam int RUN_PAUSE_BIT   = 6;
  localparam int RUN_IEN_BIT     = 5;
  localparam int RUN_MATCH_BIT   = 2;
  localparam int OUT_UPPER_BIT   = 7;
  localparam int OUT_LOWER_BIT   = 6;
  localparam int OUT_CASCADE_BIT = 4;

  localparam logic [3:0] FUNC_ONE_SHOT   = 4'h0;
  localparam logic [3:0] FUNC_CONTINUOUS = 4'h1;

  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] COUNT_START = 8'h00;
  localparam logic [3:0] NUM_HALVES  = 4'h4;

  // ************************************************************
  // request numbers and vector addresses per half (u0lo,u0hi,u1lo,u1hi)
  // ************************************************************
  localparam logic [7:0] IRQ_NUM_U0_LO = 8'h05;
  localparam logic [7:0] IRQ_NUM_U0_HI = 8'h06;
  localparam logic [7:0] IRQ_NUM_U1_LO = 8'h16;
  localparam logic [7:0] IRQ_NUM_U1_HI = 8'h0E;
  localparam logic [15:0] VEC_U0_LO = 16'hFFF0;
  localparam logic [15:0] VEC_U0_HI = 16'hFFEE;
  localparam logic [15:0] VEC_U1_LO = 16'hFFCE;
  localparam logic [15:0] VEC_U1_HI = 16'hFFDE;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b11
  } run_state_e;

  typedef struct packed {
    logic [3:0] reqLine;   // one request per half, IRQ05/06/22/14 order
    logic [3:0] reqMatch;  // raw match pulses
  } irq_bundle_s;

endpackage

// *** core/cit_counter.sv ***
// module: one 8-bit interval counter half with compare latch
`timescale 1ns/100ps
module cit_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,   // system clock
  input  wire logic             reset,      // async reset, high
  input  wire logic             countTick,  // selected count clock edge
  input  wire logic             startReq,   // pulse: run request set
  input  wire logic             stopReq,    // pulse: run request cleared
  input  wire logic             continuous, // 1 continuous, 0 one-shot
  input  wire logic             carryIn,    // cascade enable of this half
  input  wire logic [WIDTH-1:0] compareData,// compare-data register
  output logic                  running,    // counter active
  output logic                  matchPulse, // one-cycle match
  output logic [WIDTH-1:0]      countValue  // counter value
);
  import cit_pkg::*;

  initial begin
    if (WIDTH < 1 || WIDTH > 16) $error("cit_counter width unsupported");
  end

  run_state_e            state;
  run_state_e            next_state;
  logic [WIDTH-1:0]      holdLatch;
  logic [WIDTH-1:0]      next_holdLatch;
  logic [WIDTH-1:0]      next_countValue;
  logic                  hit;

  assign running = (state != ST_IDLE);
  assign hit = (state == ST_COUNT) && countTick && carryIn &&
               (countValue == holdLatch);
  assign matchPulse = hit;

  always_comb begin
    next_state      = state;
    next_holdLatch  = holdLatch;
    next_countValue = countValue;
    unique case (state)
      ST_IDLE: begin
        if (startReq) begin
          next_state      = ST_ARMED;
          next_holdLatch  = compareData;
          next_countValue = WIDTH'(COUNT_START);
        end
      end
      ST_ARMED: begin
        // counting begins on the next selected count clock edge
        if (stopReq) next_state = ST_IDLE;
        else if (countTick) next_state = ST_COUNT;
      end
      ST_COUNT: begin
        if (stopReq) begin
          next_state = ST_IDLE;
        end else if (hit) begin
          next_countValue = WIDTH'(COUNT_START);
          if (continuous) next_holdLatch = compareData;
          else next_state = ST_IDLE;
        end else if (countTick && carryIn) begin
          next_countValue = countValue + WIDTH'(1);
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state      <= ST_IDLE;
      holdLatch  <= '0;
      countValue <= '0;
    end else begin
      state      <= next_state;
      holdLatch  <= next_holdLatch;
      countValue <= next_countValue;
    end
  end

  // latch is untouched while counting unless continuous match reloads it
  latch_stable_a: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_COUNT && !hit) |=> $stable(holdLatch))
    else $error("compare latch changed mid interval");

  oneshot_halt_a: assert property (@(posedge core_clk) disable iff (reset)
    (hit && !continuous && !stopReq) |=> state == ST_IDLE)
    else $error("one-shot did not halt on match");

  cont_restart_a: assert property (@(posedge core_clk) disable iff (reset)
    (hit && continuous && !stopReq) |=>
      (countValue == '0 && state == ST_COUNT))
    else $error("continuous did not restart from zero");

endmodule // cit_counter

// *** core/composite_interval_timer.sv ***
// module: two-unit 8/16-bit composite interval timer with APB registers
`timescale 1ns/100ps
module composite_interval_timer #(
  parameter int NUM_UNITS = 2
) (
  input  wire logic        core_clk,  // 125 MHz system clock
  input  wire logic        reset,     // async reset, active high
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB access phase
  input  wire logic        pwrite,    // APB direction
  input  wire logic [31:0] pwdata,    // APB write data
  input  wire logic [3:0]  pstrb,     // APB byte strobes
  output logic [31:0]      prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error on unmapped address
  input  wire logic [1:0]  countTickPin, // count clock per unit, async
  output logic [3:0]       timerOut,  // output levels u0lo,u0hi,u1lo,u1hi
  output cit_pkg::irq_bundle_s irqInfo, // per-half requests and matches
  output logic [15:0]      vectorAddr,  // vector of highest pending half
  output logic [7:0]       irqNumber,   // request number of that half
  output logic             irq          // combined masked interrupt
);
  import cit_pkg::*;

  initial begin
    if (NUM_UNITS < 1 || NUM_UNITS > 2) $error("NUM_UNITS must be 1 or 2");
  end

  // ************************************************************
  // register storage, per-half arrays indexed by h = unit*2 + upper, per-unit ones by unit
  // ************************************************************
  logic [7:0] funcReg   [4];
  logic [7:0] runReg    [4];
  logic [7:0] dataReg   [4];
  logic [7:0] outMode   [2];
  logic [7:0] wrBuf     [2];
  logic [7:0] rdBuf     [2];
  logic [3:0] irqStatus;
  logic [3:0] irqMask;
  logic [7:0] next_funcReg [4];
  logic [7:0] next_runReg  [4];
  logic [7:0] next_dataReg [4];
  logic [7:0] next_outMode [2];
  logic [7:0] next_wrBuf   [2];
  logic [7:0] next_rdBuf   [2];
  logic [3:0] next_irqStatus;
  logic [3:0] next_irqMask;
  logic [31:0] next_prdata;

  // ************************************************************
  // count clock synchroniser and edge detect
  // ************************************************************
  logic [1:0] tickMeta, tickSync, tickLast;
  logic [1:0] tickRise;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tickMeta <= 2'h0;
      tickSync <= 2'h0;
      tickLast <= 2'h0;
    end else begin
      tickMeta <= countTickPin;
      tickSync <= tickMeta;
      tickLast <= tickSync;
    end
  end
  assign tickRise = tickSync & ~tickLast;

  // ************************************************************
  // counters
  // ************************************************************
  logic [3:0] running, match, startReq, stopReq, cascaded;
  logic [7:0] countVal [4];
  logic [1:0] lowWrap;

  function automatic logic [1:0] unit_of(input logic [7:0] a);
    unit_of = (a >= OFS_UNIT_STRIDE && a < OFS_IRQ_STATUS) ? 2'h1 : 2'h0;
  endfunction

  function automatic logic is_oneshot(input logic [7:0] f);
    is_oneshot = (f[3:0] == FUNC_ONE_SHOT);
  endfunction

  for (genvar h = 0; h < 4; h++) begin : g_half
    localparam int U = h / 2;
    logic carry;
    // upper half of a cascaded pair advances on lower wrap only
    assign carry = (h % 2 == 1 && cascaded[h]) ? lowWrap[U] : 1'b1;
    if (U < NUM_UNITS) begin : g_on
      cit_counter #(.WIDTH(8)) u_cnt (
        .core_clk    (core_clk),
        .reset       (reset),
        .countTick   (tickRise[U]),
        .startReq    (startReq[h]),
        .stopReq     (stopReq[h]),
        .continuous  (funcReg[h][3:0] == FUNC_CONTINUOUS),
        .carryIn     (carry),
        .compareData (dataReg[h]),
        .running     (running[h]),
        .matchPulse  (match[h]),
        .countValue  (countVal[h])
      );
    end else begin : g_off
      assign running[h]  = 1'b0;
      assign match[h]    = 1'b0;
      assign countVal[h] = RESET_BYTE;
    end
  end
  for (genvar u = 0; u < 2; u++) begin : g_unit
    assign cascaded[2*u]   = outMode[u][OUT_CASCADE_BIT];
    assign cascaded[2*u+1] = outMode[u][OUT_CASCADE_BIT];
    assign lowWrap[u] = tickRise[u] && countVal[2*u] == 8'hFF;
  end

  // ************************************************************
  // APB decode and register next values
  // ************************************************************
  logic       wrEn, rdEn, rdSetup, mapped;
  logic [1:0] u;
  assign wrEn = psel && penable && pwrite && pstrb[0];
  assign rdEn = psel && penable && !pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign u    = unit_of(paddr);
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'h0) &&
                  ((paddr <= OFS_U0_DATA_HI) ||
                   (paddr >= OFS_U1_FUNC_LO && paddr <= OFS_U1_DATA_HI) ||
                   paddr == OFS_IRQ_STATUS || paddr == OFS_IRQ_MASK);
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    logic [7:0] ofs;
    logic [1:0] hl, hh;
    logic [1:0] hr;
    ofs = paddr - ((u == 2'h1) ? OFS_UNIT_STRIDE : 8'h00);
    hl  = 2'(u * 2);
    hh  = 2'(u * 2 + 1);
    hr  = (ofs == OFS_U0_RUN_LO) ? hl : hh;
    next_funcReg   = funcReg;
    next_runReg    = runReg;
    next_dataReg   = dataReg;
    next_outMode   = outMode;
    next_wrBuf     = wrBuf;
    next_rdBuf     = rdBuf;
    next_irqMask   = irqMask;
    next_irqStatus = irqStatus;
    next_prdata    = 32'h0000_0000;
    startReq = 4'h0;
    stopReq  = 4'h0;
    if (wrEn && mapped) begin
      unique case (ofs)
        OFS_U0_FUNC_LO: next_funcReg[hl] = pwdata[7:0];
        OFS_U0_FUNC_HI: next_funcReg[hh] = pwdata[7:0];
        OFS_U0_RUN_LO, OFS_U0_RUN_HI: begin
          next_runReg[hr] = pwdata[7:0];
          // software may only clear the match flag, never set it
          next_runReg[hr][RUN_MATCH_BIT] =
            runReg[hr][RUN_MATCH_BIT] & pwdata[RUN_MATCH_BIT];
          next_runReg[hr][RUN_PAUSE_BIT] = 1'b0;
          if (pwdata[RUN_REQ_BIT] && !running[hr])
            startReq[hr] = 1'b1;
          if (!pwdata[RUN_REQ_BIT] && running[hr]) stopReq[hr] = 1'b1;
        end
        OFS_U0_OUTMODE: next_outMode[u[0]] = pwdata[7:0];
        OFS_U0_DATA_LO: begin
          next_dataReg[hl] = pwdata[7:0];
          if (cascaded[hl]) next_dataReg[hh] = wrBuf[u[0]];
        end
        OFS_U0_DATA_HI: begin
          if (cascaded[hh]) next_wrBuf[u[0]] = pwdata[7:0];
          else next_dataReg[hh] = pwdata[7:0];
        end
        OFS_IRQ_STATUS:
          if (u == 2'h0) next_irqStatus = irqStatus & ~pwdata[3:0];
        OFS_IRQ_MASK:
          if (u == 2'h0) next_irqMask = pwdata[3:0];
        default: ;
      endcase
    end
    // fetched in the setup phase so a flop holds it through the access
    // phase; a value changing in between is seen by the next read only
    if (rdSetup && mapped) begin
      unique case (ofs)
        OFS_U0_FUNC_LO: next_prdata[7:0] = funcReg[hl];
        OFS_U0_FUNC_HI: next_prdata[7:0] = funcReg[hh];
        OFS_U0_RUN_LO:  next_prdata[7:0] = runReg[hl];
        OFS_U0_RUN_HI:  next_prdata[7:0] = runReg[hh];
        OFS_U0_OUTMODE: next_prdata[7:0] = outMode[u[0]];
        OFS_U0_DATA_LO:
          next_prdata[7:0] = cascaded[hl] ? rdBuf[u[0]] : dataReg[hl];
        OFS_U0_DATA_HI: next_prdata[7:0] = dataReg[hh];
        OFS_IRQ_STATUS:
          if (u == 2'h0) next_prdata[3:0] = irqStatus;
        OFS_IRQ_MASK:
          if (u == 2'h0) next_prdata[3:0] = irqMask;
        default: ;
      endcase
    end
    // the snapshot itself waits for the completing access edge
    if (rdEn && mapped && ofs == OFS_U0_DATA_HI && cascaded[hh])
      next_rdBuf[u[0]] = dataReg[hl];
    // hardware events: set wins over any clear in the same cycle
    for (int h = 0; h < 4; h++) begin
      if (match[h]) begin
        next_runReg[h][RUN_MATCH_BIT] = 1'b1;
        if (is_oneshot(funcReg[h]))
          next_runReg[h][RUN_REQ_BIT] = 1'b0;
        next_irqStatus[h] = 1'b1;
      end else if (!running[h] && !startReq[h]) begin
        next_runReg[h][RUN_REQ_BIT] = 1'b0;
      end
    end
    // output level bits toggle on match and hold on stop
    for (int v = 0; v < 2; v++) begin
      if (match[2*v])   next_outMode[v][OUT_LOWER_BIT] =
                          ~outMode[v][OUT_LOWER_BIT];
      if (match[2*v+1]) next_outMode[v][OUT_UPPER_BIT] =
                          ~outMode[v][OUT_UPPER_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int h = 0; h < 4; h++) begin
        funcReg[h] <= RESET_BYTE;
        runReg[h]  <= RESET_BYTE;
        dataReg[h] <= RESET_BYTE;
      end
      for (int v = 0; v < 2; v++) begin
        outMode[v] <= RESET_BYTE;
        wrBuf[v]   <= RESET_BYTE;
        rdBuf[v]   <= RESET_BYTE;
      end
      irqStatus <= 4'h0;
      irqMask   <= 4'h0;
      prdata    <= 32'h0000_0000;
    end else begin
      funcReg   <= next_funcReg;
      runReg    <= next_runReg;
      dataReg   <= next_dataReg;
      outMode   <= next_outMode;
      wrBuf     <= next_wrBuf;
      rdBuf     <= next_rdBuf;
      irqStatus <= next_irqStatus;
      irqMask   <= next_irqMask;
      prdata    <= next_prdata;
    end
  end

  // ************************************************************
  // interrupt requests
  // ************************************************************
  logic [3:0] reqLine;
  for (genvar h = 0; h < 4; h++) begin : g_req
    assign reqLine[h] = runReg[h][RUN_MATCH_BIT] &&
                        runReg[h][RUN_IEN_BIT] &&
                        funcReg[h][FUNC_GATE_BIT] &&
                        !(h % 2 == 1 && cascaded[h]) &&
                        (h / 2 < NUM_UNITS);
  end
  assign irqInfo.reqLine  = reqLine;
  assign irqInfo.reqMatch = match;
  assign irq = |(irqStatus & irqMask & {~cascaded[3], 1'b1,
                                        ~cascaded[1], 1'b1});
  for (genvar v = 0; v < 2; v++) begin : g_out
    assign timerOut[2*v]   = outMode[v][OUT_LOWER_BIT];
    assign timerOut[2*v+1] = outMode[v][OUT_UPPER_BIT];
  end

  always_comb begin
    vectorAddr = 16'h0000;
    irqNumber  = 8'h00;
    if (reqLine[0]) begin
      vectorAddr = VEC_U0_LO;
      irqNumber  = IRQ_NUM_U0_LO;
    end else if (reqLine[1]) begin
      vectorAddr = VEC_U0_HI;
      irqNumber  = IRQ_NUM_U0_HI;
    end else if (reqLine[3]) begin
      vectorAddr = VEC_U1_HI;
      irqNumber  = IRQ_NUM_U1_HI;
    end else if (reqLine[2]) begin
      vectorAddr = VEC_U1_LO;
      irqNumber  = IRQ_NUM_U1_LO;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  match_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    match[0] |=> runReg[0][RUN_MATCH_BIT])
    else $error("match flag not set");
  toggle_out_a: assert property (@(posedge core_clk) disable iff (reset)
    match[0] |=> timerOut[0] != $past(timerOut[0]))
    else $error("output did not toggle on match");
  hold_out_a: assert property (@(posedge core_clk) disable iff (reset)
    (!match[0] && !(wrEn && mapped && paddr == OFS_U0_OUTMODE)) |=>
      timerOut[0] == $past(timerOut[0]))
    else $error("output changed without match");
  req_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    reqLine[0] |-> (runReg[0][RUN_IEN_BIT] && funcReg[0][FUNC_GATE_BIT]))
    else $error("request without enables");
  cascade_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
    cascaded[1] |-> !reqLine[1])
    else $error("upper half requested in cascade");
  vector_map_a: assert property (@(posedge core_clk) disable iff (reset)
    reqLine[0] |-> (vectorAddr == VEC_U0_LO && irqNumber == IRQ_NUM_U0_LO))
    else $error("wrong vector for unit0 lower");
  wr_commit_a: assert property (@(posedge core_clk) disable iff (reset)
    (wrEn && paddr == OFS_U0_DATA_LO && cascaded[0]) |=>
      dataReg[1] == $past(wrBuf[0]))
    else $error("upper byte not committed");
  start_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    startReq[0] |=> countVal[0] == 8'h00 ##1 running[0])
    else $error("start did not clear counter");

  start_c:   cover property (@(posedge core_clk) startReq[0]);
  oneshot_c: cover property (@(posedge core_clk)
    match[0] && is_oneshot(funcReg[0]));
  cont_c:    cover property (@(posedge core_clk)
    match[2] ##[1:600] match[2]);
  irq_c:     cover property (@(posedge core_clk) irq);

endmodule // composite_interval_timer

// *** test/tick_source.sv ***
// partner: count clock source that drives the timer tick pins
`timescale 1ns/100ps
module tick_source #(
  parameter int HALF = 4
) (
  input  wire logic       core_clk, // system clock
  input  wire logic       run,      // emit ticks while high
  output logic [1:0]      tickPin   // count clock per unit
);
  int cnt = 0;
  initial tickPin = 2'b00;
  // held low between runs so that no stray count slips in
  always @(posedge core_clk) begin
    cnt <= run ? (cnt + 1) % HALF : 0;
    if (!run)
      tickPin <= 2'b00;
    else if (cnt == HALF - 1)
      tickPin <= ~tickPin;
  end
endmodule // tick_source

// *** test/testbench.sv ***
// testbench: register, interval and interrupt scenarios of the timer
`timescale 1ns/100ps
module testbench;
  import cit_pkg::*;
  logic        core_clk, reset, psel, penable, pwrite, tickRun;
  logic        pready, pslverr, irq, err;
  logic [7:0]  paddr, irqNumber;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, timerOut;
  logic [1:0]  tickPin;
  logic [15:0] vectorAddr;
  irq_bundle_s irqInfo;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;

  composite_interval_timer dut (.core_clk(core_clk), .reset(reset),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countTickPin(tickPin), .timerOut(timerOut),
    .irqInfo(irqInfo), .vectorAddr(vectorAddr), .irqNumber(irqNumber),
    .irq(irq));
  tick_source partner (.core_clk(core_clk), .run(tickRun),
    .tickPin(tickPin));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read data stands through the access phase and is taken at its edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    paddr <= a;
    pwdata <= {24'h0, d};
    pwrite <= w;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic waitMatch(input int i, input int lim);
    n = 0;
    while (irqInfo.reqMatch[i] !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, tickRun} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h1;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    xfer(1'b0, OFS_U0_RUN_LO, 8'h00);
    check(rd, 32'h0);
    xfer(1'b0, 8'h7C, 8'h00);
    check(err, 1); // unmapped refused
    check(rd, 32'h0);
    // one-shot, compare rewritten while running
    xfer(1'b1, OFS_U0_FUNC_LO, {1'b1, 3'h0, FUNC_ONE_SHOT});
    xfer(1'b1, OFS_U0_DATA_LO, 8'h03);
    xfer(1'b1, OFS_IRQ_MASK, 8'h05);
    xfer(1'b1, OFS_U0_RUN_LO, 8'hA0);
    xfer(1'b1, OFS_U0_DATA_LO, 8'h40);
    tickRun <= 1'b1;
    waitMatch(0, 700);
    check(n > 16 && n < 60, 1);
    check({timerOut[0], irqInfo.reqLine[0], irq}, 3'b111);
    check({irqNumber, vectorAddr}, {IRQ_NUM_U0_LO, VEC_U0_LO});
    repeat (100) @(posedge core_clk);
    xfer(1'b0, OFS_U0_RUN_LO, 8'h00);
    check(rd, 32'h24);
    check(timerOut[0], 1);
    xfer(1'b1, OFS_U0_FUNC_LO, 8'h00);
    check(irqInfo.reqLine[0], 0);
    xfer(1'b1, OFS_U0_RUN_LO, 8'h20);
    xfer(1'b1, OFS_IRQ_STATUS, 8'h0F);
    check(irq, 0);
    // re-armed interval picks up the rewritten compare value
    xfer(1'b1, OFS_U0_RUN_LO, 8'hA0);
    waitMatch(0, 700);
    check(n > 480 && n < 560, 1);
    check(timerOut[0], 0);
    // continuous on unit 1 lower, period of three counts
    xfer(1'b1, OFS_U1_FUNC_LO, {1'b1, 3'h0, FUNC_CONTINUOUS});
    xfer(1'b1, OFS_U1_DATA_LO, 8'h02);
    xfer(1'b1, OFS_U1_RUN_LO, 8'hA0);
    waitMatch(2, 700);
    for (int k = 1; k < 4; k++) begin
      check(timerOut[2], k % 2);
      waitMatch(2, 700);
      check(n >= 20 && n <= 26, 1);
    end
    // an odd match count leaves the level high, unlike its reset value
    waitMatch(2, 700);
    check({irqNumber, vectorAddr}, {IRQ_NUM_U1_LO, VEC_U1_LO});
    xfer(1'b1, OFS_U1_RUN_LO, 8'h20);
    repeat (100) @(posedge core_clk);
    check(timerOut[2], 1);
    tickRun <= 1'b0;
    // cascaded data: upper byte waits for the lower write
    xfer(1'b1, OFS_U0_OUTMODE, 8'h10);
    xfer(1'b1, OFS_U0_DATA_HI, 8'h12);
    xfer(1'b0, OFS_U0_DATA_HI, 8'h00);
    check(rd, 32'h0);
    xfer(1'b1, OFS_U0_DATA_LO, 8'h34);
    xfer(1'b0, OFS_U0_DATA_HI, 8'h00);
    check(rd, 32'h12);
    xfer(1'b0, OFS_U0_DATA_LO, 8'h00);
    check(rd, 32'h34);
    summarize();
  end
endmodule // testbench
